// [src/pdt_pkg.sv]
// Package with register map, reset values, field layouts and timing constants
package pdt_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [15:0] ADDR_BIT_PERIOD = 16'h1A07;
	localparam logic [15:0] ADDR_TURNAROUND = 16'h1A08;
	localparam logic [15:0] ADDR_TX_ABORT   = 16'h1A09;
	localparam logic [15:0] ADDR_AR_ABORT   = 16'h1A0A;
	localparam logic [15:0] ADDR_POWERUP    = 16'h1A0B;
	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] RST_BIT_PERIOD = 8'h00;
	localparam logic [5:0] RST_TURNAROUND = 6'h15;
	localparam logic [7:0] RST_POWERUP    = 8'h00;
	localparam logic [7:0] MASK_TX_ABORT  = 8'hF7;
	localparam logic [7:0] MASK_AR_ABORT  = 8'h4A;
	// ==========================================================
	// Abort cause bit positions
	localparam int TXA_GO_DISABLED = 0;
	localparam int TXA_SW_ABORT    = 1;
	localparam int TXA_SW_BUSY     = 2;
	localparam int TXA_RETRY_BUSY  = 4;
	localparam int TXA_RETRY_RX    = 5;
	localparam int TXA_SW_RX       = 6;
	localparam int TXA_CRC_WAIT    = 7;
	localparam int ARA_SW_ABORT    = 1;
	localparam int ARA_BUSY        = 3;
	localparam int ARA_RX          = 6;
	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          US_NS         = 1000;
	localparam int          US_CYCLES     = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] PU_EXTRA      = 11'h005;
	// ==========================================================
	// Transmit sequencer states and request sources
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_TA   = 5'h02,
		ST_LINE = 5'h04,
		ST_PWR  = 5'h08,
		ST_SEND = 5'h10
	} pdt_state_t;
	typedef enum logic [1:0] {
		SRC_SW    = 2'h0,
		SRC_RETRY = 2'h1,
		SRC_AR    = 2'h2
	} pdt_src_t;
endpackage

// [src/pdt_abort_if.sv]
// Interface between sequencer and one sticky abort cause register
`timescale 1ns/100ps
interface pdt_abort_if;
	logic [7:0] set;
	logic [7:0] clr;
	logic [7:0] val;
	modport log  (input set, input clr, output val);
	modport user (output set, output clr, input val);
endinterface

// [src/pdt_divider.sv]
// Reloadable down counter giving one tick every reload plus one cycles
`timescale 1ns/100ps
module pdt_divider #(
	parameter int W = 8
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] reload_i,
	output logic              tick_o
);
	generate
		if (W < 1 || W > 16) begin : g_bad_width
			$error("pdt_divider width out of range");
		end
	endgenerate

	typedef struct packed {
		logic [W-1:0] cnt;
	} pdt_div_t;

	pdt_div_t q, d;

	always_comb begin
		d = q;
		if (!en_i) begin
			d.cnt = reload_i;
		end else if (q.cnt == '0) begin
			d.cnt = reload_i;
		end else begin
			d.cnt = q.cnt - W'(1);
		end
	end

	assign tick_o = en_i && (q.cnt == '0);

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // pdt_divider

// [src/pdt_abort_log.sv]
// Sticky write-one-to-clear abort cause register
`timescale 1ns/100ps
module pdt_abort_log #(
	parameter logic [7:0] MASK = 8'hFF
) (
	input  wire logic      clk_sys_i,
	input  wire logic      reset_i,
	pdt_abort_if.log       ab
);
	typedef struct packed {
		logic [7:0] val;
	} pdt_log_t;

	pdt_log_t   q, d;
	logic [7:0] kept;

	always_comb begin
		d    = q;
		kept = q.val & ~(ab.clr & MASK);
		if (kept == 8'h00) begin
			d.val = ab.set & MASK;
		end else begin
			d.val = kept;
		end
	end

	assign ab.val = q.val;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	AST_STICKY_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.val != 8'h00 && ab.clr == 8'h00) |=> q.val == $past(q.val))
		else $error("abort cause changed while held");
	AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.val & ~MASK) == 8'h00)
		else $error("reserved abort bit set");
endmodule // pdt_abort_log

// [src/pdt_tx_timing.sv]
// Transmit timing, turnaround, power-up hold-off and abort cause bookkeeping
`timescale 1ns/100ps
module pdt_tx_timing (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        tx_en_i,
	input  wire logic        tx_go_i,
	input  wire logic        tx_retry_i,
	input  wire logic        tx_auto_rsp_i,
	input  wire logic        sw_abort_i,
	input  wire logic        rx_start_i,
	input  wire logic        line_busy_i,
	input  wire logic        crc_wait_err_i,
	input  wire logic        tx_done_i,
	output logic             bit_tick_o,
	output logic             tx_active_o,
	output logic             tx_power_en_o,
	output logic             tx_send_o,
	output logic             tx_abort_event_o,
	output logic             auto_response_abort_event_o
);
	// ==========================================================
	// State
	typedef struct packed {
		pdt_pkg::pdt_state_t st;
		pdt_pkg::pdt_src_t   src;
		logic [7:0]          bit_period_count;
		logic [5:0]          turnaround_time_us;
		logic [7:0]          powerup;
		logic [5:0]          ta_cnt;
		logic [10:0]         pu_cnt;
		logic [7:0]          rdata;
		logic                tx_evt;
		logic                ar_evt;
		logic [7:0]          gap;
		logic [10:0]         pwr_run;
		logic [5:0]          ta_ticks;
	} pdt_top_t;

	pdt_top_t   q, d;
	logic       us_tick;
	logic       bit_tick;
	logic [7:0] tx_set;
	logic [7:0] ar_set;
	logic [7:0] tx_clr;
	logic [7:0] ar_clr;
	logic       waiting;
	logic       do_abort;

	pdt_abort_if ab_tx ();
	pdt_abort_if ab_ar ();

	// ==========================================================
	// Timebases
	pdt_divider #(.W(8)) u_us_tick (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.en_i      (1'b1),
		.reload_i  (8'(pdt_pkg::US_CYCLES - 1)),
		.tick_o    (us_tick)
	);

	pdt_divider #(.W(8)) u_bit_timer (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.en_i      (q.st == pdt_pkg::ST_SEND),
		.reload_i  (q.bit_period_count),
		.tick_o    (bit_tick)
	);

	// ==========================================================
	// Abort cause registers
	pdt_abort_log #(.MASK(pdt_pkg::MASK_TX_ABORT)) u_tx_abort (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ab        (ab_tx)
	);

	pdt_abort_log #(.MASK(pdt_pkg::MASK_AR_ABORT)) u_ar_abort (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ab        (ab_ar)
	);

	assign ab_tx.set = tx_set;
	assign ab_tx.clr = tx_clr;
	assign ab_ar.set = ar_set;
	assign ab_ar.clr = ar_clr;

	// ==========================================================
	// Next state
	always_comb begin
		d          = q;
		d.tx_evt   = 1'b0;
		d.ar_evt   = 1'b0;
		tx_set     = 8'h00;
		ar_set     = 8'h00;
		tx_clr     = 8'h00;
		ar_clr     = 8'h00;
		do_abort   = 1'b0;
		waiting    = (q.st == pdt_pkg::ST_TA) || (q.st == pdt_pkg::ST_LINE);

		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				pdt_pkg::ADDR_BIT_PERIOD: d.bit_period_count   = reg_wdata_i;
				pdt_pkg::ADDR_TURNAROUND: d.turnaround_time_us = reg_wdata_i[5:0];
				pdt_pkg::ADDR_TX_ABORT:   tx_clr               = reg_wdata_i;
				pdt_pkg::ADDR_AR_ABORT:   ar_clr               = reg_wdata_i;
				pdt_pkg::ADDR_POWERUP:    d.powerup            = reg_wdata_i;
				default:                  d.powerup            = q.powerup;
			endcase
		end

		// Register reads, one cycle latency
		if (reg_rd_i) begin
			case (reg_addr_i)
				pdt_pkg::ADDR_BIT_PERIOD: d.rdata = q.bit_period_count;
				pdt_pkg::ADDR_TURNAROUND: d.rdata = {2'h0, q.turnaround_time_us};
				pdt_pkg::ADDR_TX_ABORT:   d.rdata = ab_tx.val;
				pdt_pkg::ADDR_AR_ABORT:   d.rdata = ab_ar.val;
				pdt_pkg::ADDR_POWERUP:    d.rdata = q.powerup;
				default:                  d.rdata = 8'h00;
			endcase
		end

		// Sequencer
		case (q.st)
			pdt_pkg::ST_IDLE: begin
				if (tx_go_i && !tx_en_i) begin
					tx_set[pdt_pkg::TXA_GO_DISABLED] = 1'b1;
				end else if (tx_en_i && (tx_go_i || tx_retry_i || tx_auto_rsp_i)) begin
					d.st     = pdt_pkg::ST_TA;
					d.ta_cnt = q.turnaround_time_us;
					if (tx_go_i) begin
						d.src = pdt_pkg::SRC_SW;
					end else if (tx_retry_i) begin
						d.src = pdt_pkg::SRC_RETRY;
					end else begin
						d.src = pdt_pkg::SRC_AR;
					end
				end
			end
			pdt_pkg::ST_TA: begin
				if (us_tick) begin
					if (q.ta_cnt == 6'h01) begin
						d.st = pdt_pkg::ST_LINE;
					end else begin
						d.ta_cnt = q.ta_cnt - 6'h01;
					end
				end
			end
			pdt_pkg::ST_LINE: begin
				if (line_busy_i) begin
					do_abort = 1'b1;
					case (q.src)
						pdt_pkg::SRC_SW:    tx_set[pdt_pkg::TXA_SW_BUSY]    = 1'b1;
						pdt_pkg::SRC_RETRY: tx_set[pdt_pkg::TXA_RETRY_BUSY] = 1'b1;
						default:            ar_set[pdt_pkg::ARA_BUSY]       = 1'b1;
					endcase
				end else begin
					d.st     = pdt_pkg::ST_PWR;
					d.pu_cnt = {q.powerup, 3'h0} + pdt_pkg::PU_EXTRA;
				end
			end
			pdt_pkg::ST_PWR: begin
				if (q.pu_cnt == 11'h001) begin
					d.st = pdt_pkg::ST_SEND;
				end else begin
					d.pu_cnt = q.pu_cnt - 11'h001;
				end
			end
			pdt_pkg::ST_SEND: begin
				if (tx_done_i) begin
					d.st = pdt_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = pdt_pkg::ST_IDLE;
			end
		endcase

		// Reception during turnaround or line idle wait
		if (waiting && rx_start_i) begin
			do_abort = 1'b1;
			case (q.src)
				pdt_pkg::SRC_SW:    tx_set[pdt_pkg::TXA_SW_RX]    = 1'b1;
				pdt_pkg::SRC_RETRY: tx_set[pdt_pkg::TXA_RETRY_RX] = 1'b1;
				default:            ar_set[pdt_pkg::ARA_RX]       = 1'b1;
			endcase
		end

		// Software abort of an activity in progress
		if (sw_abort_i && q.st != pdt_pkg::ST_IDLE) begin
			do_abort = 1'b1;
			if (q.src == pdt_pkg::SRC_AR) begin
				ar_set[pdt_pkg::ARA_SW_ABORT] = 1'b1;
			end else begin
				tx_set[pdt_pkg::TXA_SW_ABORT] = 1'b1;
			end
		end

		// Protocol error while awaiting GoodCRC
		if (crc_wait_err_i) begin
			tx_set[pdt_pkg::TXA_CRC_WAIT] = 1'b1;
		end

		if (do_abort) begin
			d.st = pdt_pkg::ST_IDLE;
		end

		d.tx_evt = |tx_set;
		d.ar_evt = |ar_set;

		// Observation counters
		d.gap      = (q.st == pdt_pkg::ST_SEND && !bit_tick) ? q.gap + 8'h01 : 8'h00;
		d.pwr_run  = (q.st == pdt_pkg::ST_PWR) ? q.pwr_run + 11'h001 : 11'h000;
		d.ta_ticks = (q.st != pdt_pkg::ST_TA) ? 6'h00 :
			(us_tick ? q.ta_ticks + 6'h01 : q.ta_ticks);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			q                    <= '0;
			q.st                 <= pdt_pkg::ST_IDLE;
			q.src                <= pdt_pkg::SRC_SW;
			q.bit_period_count   <= pdt_pkg::RST_BIT_PERIOD;
			q.turnaround_time_us <= pdt_pkg::RST_TURNAROUND;
			q.powerup            <= pdt_pkg::RST_POWERUP;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata_o                 = q.rdata;
	assign bit_tick_o                  = bit_tick;
	assign tx_active_o                 = (q.st != pdt_pkg::ST_IDLE);
	assign tx_power_en_o               = (q.st == pdt_pkg::ST_PWR) || (q.st == pdt_pkg::ST_SEND);
	assign tx_send_o                   = (q.st == pdt_pkg::ST_SEND);
	assign tx_abort_event_o            = q.tx_evt;
	assign auto_response_abort_event_o = q.ar_evt;

	// ==========================================================
	// Assertions
	AST_BIT_PERIOD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(bit_tick && $stable(q.bit_period_count)) |-> q.gap == q.bit_period_count)
		else $error("bit period length wrong");

	AST_POWERUP_HOLD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_SEND && $past(q.st) == pdt_pkg::ST_PWR)
		|-> $past(q.pwr_run) == 11'({$past(q.powerup), 3'h0} + 11'h004))
		else $error("power-up hold-off length wrong");

	AST_TA_TICKS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_LINE && $past(q.st) == pdt_pkg::ST_TA)
		|-> 6'($past(q.ta_ticks) + 6'h01) == $past(q.turnaround_time_us))
		else $error("turnaround tick count wrong");

	AST_SW_BUSY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_LINE && line_busy_i && q.src == pdt_pkg::SRC_SW
			&& ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_SW_BUSY] && tx_abort_event_o
			&& q.st == pdt_pkg::ST_IDLE)
		else $error("software busy abort not recorded");

	AST_AR_BUSY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_LINE && line_busy_i && q.src == pdt_pkg::SRC_AR
			&& ab_ar.val == 8'h00)
		|=> ab_ar.val[pdt_pkg::ARA_BUSY] && auto_response_abort_event_o)
		else $error("auto-response busy abort not recorded");

	AST_RETRY_RX: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(waiting && rx_start_i && q.src == pdt_pkg::SRC_RETRY && ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_RETRY_RX] && !tx_active_o)
		else $error("retry reception abort not recorded");

	AST_GO_DISABLED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_IDLE && tx_go_i && !tx_en_i && ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_GO_DISABLED] && !tx_active_o)
		else $error("launch while disabled not recorded");

	AST_SW_ABORT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(tx_active_o && sw_abort_i && q.src == pdt_pkg::SRC_SW && ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_SW_ABORT] && !tx_active_o)
		else $error("software abort not recorded");

	AST_EVENT_PAIR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		auto_response_abort_event_o |-> $past(q.src) == pdt_pkg::SRC_AR)
		else $error("auto-response event without auto response");

	AST_SW_RX: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(waiting && rx_start_i && q.src == pdt_pkg::SRC_SW && ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_SW_RX] && !tx_active_o)
		else $error("software reception abort not recorded");

	AST_RETRY_BUSY: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_LINE && line_busy_i && q.src == pdt_pkg::SRC_RETRY
			&& ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_RETRY_BUSY] && tx_abort_event_o)
		else $error("retry busy abort not recorded");

	AST_AR_RX: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(waiting && rx_start_i && q.src == pdt_pkg::SRC_AR && ab_ar.val == 8'h00)
		|=> ab_ar.val[pdt_pkg::ARA_RX] && auto_response_abort_event_o)
		else $error("auto-response reception abort not recorded");

	AST_AR_SW_ABORT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(tx_active_o && sw_abort_i && q.src == pdt_pkg::SRC_AR && ab_ar.val == 8'h00)
		|=> ab_ar.val[pdt_pkg::ARA_SW_ABORT] && !tx_active_o)
		else $error("auto-response software abort not recorded");

	AST_CRC_WAIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(crc_wait_err_i && ab_tx.val == 8'h00)
		|=> ab_tx.val[pdt_pkg::TXA_CRC_WAIT] && tx_abort_event_o)
		else $error("acknowledge wait abort not recorded");

	AST_TA_LOAD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(q.st == pdt_pkg::ST_IDLE && tx_en_i && (tx_go_i || tx_retry_i || tx_auto_rsp_i))
		|=> q.st == pdt_pkg::ST_TA && q.ta_cnt == $past(q.turnaround_time_us))
		else $error("turnaround count not loaded");

	AST_TX_EVENT_PAIR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(ab_tx.val != 8'h00 && $past(ab_tx.val) == 8'h00) |-> tx_abort_event_o)
		else $error("transmit cause set without event");
endmodule // pdt_tx_timing

// [sim/pdt_remote_port.sv]
// Model of the remote port on the CC wire: line state, reception and frame end
`timescale 1ns/100ps
module pdt_remote_port (
	input  wire logic       clk_sys_i,
	input  wire logic       send_i,
	input  wire logic       bit_tick_i,
	input  wire logic [7:0] frame_bits_i,
	input  wire logic       busy_cmd_i,
	input  wire logic       rx_cmd_i,
	input  wire logic       crc_cmd_i,
	output logic            line_busy_o,
	output logic            rx_start_o,
	output logic            crc_wait_err_o,
	output logic            tx_done_o
);
	logic [7:0] bits_q = 8'h00;
	// ==========================================================
	// Line activity and reception follow the bench commands
	assign line_busy_o    = busy_cmd_i;
	assign rx_start_o     = rx_cmd_i;
	assign crc_wait_err_o = crc_cmd_i;
	// ==========================================================
	// Frame ends once the requested number of bits went out
	initial tx_done_o = 1'b0;
	always @(negedge clk_sys_i) begin
		tx_done_o <= 1'b0;
		if (send_i !== 1'b1) begin
			bits_q <= 8'h00;
		end else if (bit_tick_i === 1'b1) begin
			bits_q <= bits_q + 8'h01;
			if (bits_q + 8'h01 == frame_bits_i) begin
				tx_done_o <= 1'b1;
			end
		end
	end
endmodule // pdt_remote_port

// [sim/tb.sv]
// Self-checking bench for the transmit timing and abort cause block
`timescale 1ns/100ps
module tb;
	localparam logic [7:0] ETX [9] = '{8'h40, 8'h04, 8'h02, 8'h20, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] EAR [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h08, 8'h02};
	logic        clk_sys_i   = 1'b0;
	logic        reset_i     = 1'b1;
	logic [15:0] reg_addr_i  = 16'h0000;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        tx_en_i     = 1'b0;
	logic [5:0]  pls         = 6'h00;
	logic        busy_cmd    = 1'b0;
	logic [7:0]  frame_bits  = 8'h03;
	logic [7:0]  reg_rdata_o;
	logic        bit_tick_o, tx_active_o, tx_power_en_o, tx_send_o;
	logic        tx_abort_event_o, auto_response_abort_event_o;
	logic        line_busy, rx_start, crc_err, tx_done;
	int          error_cnt = 0;
	int          tests_run = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	pdt_tx_timing dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .tx_en_i(tx_en_i), .tx_go_i(pls[0]), .tx_retry_i(pls[1]),
		.tx_auto_rsp_i(pls[2]), .sw_abort_i(pls[3]), .rx_start_i(rx_start),
		.line_busy_i(line_busy), .crc_wait_err_i(crc_err), .tx_done_i(tx_done),
		.bit_tick_o(bit_tick_o), .tx_active_o(tx_active_o), .tx_power_en_o(tx_power_en_o),
		.tx_send_o(tx_send_o), .tx_abort_event_o(tx_abort_event_o),
		.auto_response_abort_event_o(auto_response_abort_event_o));

	pdt_remote_port far (.clk_sys_i(clk_sys_i), .send_i(tx_send_o), .bit_tick_i(bit_tick_o),
		.frame_bits_i(frame_bits), .busy_cmd_i(busy_cmd), .rx_cmd_i(pls[4]),
		.crc_cmd_i(pls[5]), .line_busy_o(line_busy), .rx_start_o(rx_start),
		.crc_wait_err_o(crc_err), .tx_done_o(tx_done));

	// ==========================================================
	// Shared tasks
	task end_sim();
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task tmo();
		error_cnt++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		end_sim();
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		@(negedge clk_sys_i);
	endtask

	task rd(input logic [15:0] a, input logic [7:0] exp);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_i = 1'b0;
		@(negedge clk_sys_i);
		check(reg_rdata_o, exp);
	endtask

	task pulse(input int k);
		pls[k] = 1'b1;
		@(negedge clk_sys_i);
		pls = 6'h00;
	endtask

	task wait_ev(output logic [1:0] ev);
		int i;
		ev = 2'b00;
		for (i = 0; i < 400 && ev === 2'b00; i++) begin
			ev = {tx_abort_event_o, auto_response_abort_event_o};
			if (ev === 2'b00) @(negedge clk_sys_i);
		end
		if (ev === 2'b00) tmo();
	endtask

	task wait_idle();
		int i;
		for (i = 0; i < 50 && tx_active_o !== 1'b0; i++) @(negedge clk_sys_i);
		if (i == 50) tmo();
	endtask

	// ==========================================================
	// Scenarios
	task run_reset_values();
		rd(pdt_pkg::ADDR_BIT_PERIOD, pdt_pkg::RST_BIT_PERIOD);
		rd(pdt_pkg::ADDR_TURNAROUND, 8'h15);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h00);
		rd(pdt_pkg::ADDR_AR_ABORT, 8'h00);
		rd(pdt_pkg::ADDR_POWERUP, pdt_pkg::RST_POWERUP);
		rd(16'h1A0C, 8'h00);
	endtask

	task run_access();
		wr(pdt_pkg::ADDR_BIT_PERIOD, 8'hA5);
		rd(pdt_pkg::ADDR_BIT_PERIOD, 8'hA5);
		wr(pdt_pkg::ADDR_TURNAROUND, 8'hFF);
		rd(pdt_pkg::ADDR_TURNAROUND, 8'h3F);
		wr(pdt_pkg::ADDR_TX_ABORT, 8'hFF);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h00);
		wr(pdt_pkg::ADDR_AR_ABORT, 8'hFF);
		rd(pdt_pkg::ADDR_AR_ABORT, 8'h00);
		wr(pdt_pkg::ADDR_POWERUP, 8'h5A);
		rd(pdt_pkg::ADDR_POWERUP, 8'h5A);
	endtask

	task run_disabled_go();
		logic [1:0] ev;
		tx_en_i = 1'b0;
		pulse(0);
		wait_ev(ev);
		check({6'h00, ev}, 8'h02);
		check({7'h00, tx_active_o}, 8'h00);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h01);
		pulse(5);
		wait_ev(ev);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h01);
		wr(pdt_pkg::ADDR_TX_ABORT, 8'h01);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h00);
		pulse(5);
		wait_ev(ev);
		rd(pdt_pkg::ADDR_TX_ABORT, 8'h80);
		wr(pdt_pkg::ADDR_TX_ABORT, 8'hFF);
	endtask

	task run_transfer();
		int i, ta, pu, st, tk, first, last, bad;
		ta = 0; pu = 0; st = 0; tk = 0; first = 0; last = 0; bad = 0;
		wr(pdt_pkg::ADDR_BIT_PERIOD, 8'h03);
		wr(pdt_pkg::ADDR_TURNAROUND, 8'h02);
		wr(pdt_pkg::ADDR_POWERUP, 8'h01);
		tx_en_i = 1'b1;
		pulse(0);
		for (i = 0; i < 10 && tx_active_o !== 1'b1; i++) @(negedge clk_sys_i);
		if (i == 10) tmo();
		for (i = 0; i < 3000 && tx_active_o === 1'b1; i++) begin
			if (tx_power_en_o !== 1'b1) ta++;
			else if (tx_send_o !== 1'b1) pu++;
			else begin
				st++;
				if (bit_tick_o === 1'b1) begin
					if (tk == 0) first = st;
					else if (st - last != 4) bad++;
					last = st;
					tk++;
				end
			end
			@(negedge clk_sys_i);
		end
		if (i == 3000) tmo();
		check({7'h00, ta >= 100 && ta <= 202}, 8'h01);
		check(pu[7:0], 8'h0D);
		check(first[7:0], 8'h04);
		check(bad[7:0], 8'h00);
		check({7'h00, tx_power_en_o}, 8'h00);
	endtask

	task run_aborts();
		int c;
		logic [1:0] ev;
		for (c = 0; c < 9; c++) begin
			busy_cmd = (c % 3 == 1);
			pulse(c / 3);
			repeat (5) @(negedge clk_sys_i);
			if (c % 3 == 0) pulse(4);
			if (c % 3 == 2) pulse(3);
			wait_ev(ev);
			check({6'h00, ev}, {6'h00, ETX[c] != 8'h00, EAR[c] != 8'h00});
			busy_cmd = 1'b0;
			rd(pdt_pkg::ADDR_TX_ABORT, ETX[c]);
			rd(pdt_pkg::ADDR_AR_ABORT, EAR[c]);
			wr(pdt_pkg::ADDR_TX_ABORT, 8'hFF);
			wr(pdt_pkg::ADDR_AR_ABORT, 8'hFF);
			wait_idle();
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_sys_i);
		reset_i = 1'b0;
		@(negedge clk_sys_i);
		run_reset_values();
		run_access();
		run_disabled_go();
		run_transfer();
		run_aborts();
		end_sim();
	end
endmodule // tb
